// File: include/fpsc_defines.svh
// named constants for the fifo port, parity and sizing control block
`ifndef FPSC_DEFINES_SVH
`define FPSC_DEFINES_SVH

`define FPSC_DW          36
`define FPSC_LANES       4
`define FPSC_BYTE_W      9
`define FPSC_OFS_W       5
// almost-flag offsets chosen by {offset_sel_hi, offset_sel_lo}
`define FPSC_OFS_SEL_16  2'h3
`define FPSC_OFS_SEL_12  2'h2
`define FPSC_OFS_SEL_8   2'h1
`define FPSC_OFS_16      5'h10
`define FPSC_OFS_12      5'h0C
`define FPSC_OFS_8       5'h08
`define FPSC_OFS_4       5'h04
// port-B size encodings {portb_size_sel_hi, portb_size_sel_lo}
`define FPSC_SIZE_LONG   2'h0
`define FPSC_SIZE_BYTE   2'h1
`define FPSC_SIZE_WORD   2'h2
`define FPSC_SIZE_MBOX   2'h3
// byte lanes in use per size
`define FPSC_LANES_ALL   4'hF
`define FPSC_LANES_WORD  4'h3
`define FPSC_LANES_BYTE  4'h1
// position steps inside one long word
`define FPSC_POS_ZERO    2'h0
`define FPSC_POS_WORD    2'h2
`define FPSC_POS_BYTE    2'h1
// flag levels forced while the device reset pin is low
`define FPSC_FLAG_HI     1'h1
`define FPSC_FLAG_LO     1'h0

`endif

// File: include/fpsc_pkg.sv
// types shared by the fifo port, parity and sizing control block
`include "fpsc_defines.svh"

package fpsc_pkg;

  typedef enum logic [1:0] {
    FPSC_SWAP_NONE  = 2'h0,
    FPSC_SWAP_BYTE  = 2'h1,
    FPSC_SWAP_WORD  = 2'h2,
    FPSC_SWAP_BOTH  = 2'h3
  } fpsc_swap_t;

  // every pin that crosses into sys_clk_i through two flops
  typedef struct packed {
    logic                  porta_clk;
    logic                  portb_clk;
    logic                  dev_rst_n;
    logic                  porta_chip_sel_n;
    logic                  porta_enable;
    logic                  porta_write_not_read;
    logic                  porta_mbox_sel;
    logic                  portb_chip_sel_n;
    logic                  portb_enable;
    logic                  portb_write_not_read;
    logic [1:0]            portb_size_sel;
    logic                  portb_endian_sel;
    logic [1:0]            swap_sel;
    logic                  odd_even_sel;
    logic                  porta_parity_gen_en;
    logic                  portb_parity_gen_en;
    logic [1:0]            offset_sel;
    logic [`FPSC_DW-1:0]   porta_data;
    logic [`FPSC_DW-1:0]   portb_data;
  } fpsc_pins_t;

  typedef struct packed {
    fpsc_pins_t              s1;
    fpsc_pins_t              s2;
    logic                    porta_clk_d;
    logic                    portb_clk_d;
    logic                    rst_n_d;
    logic [`FPSC_OFS_W-1:0]  offset;
    logic [2:0]              size_lat;
    logic [2:0]              size_app;
    fpsc_swap_t              swap;
    logic [1:0]              pos;
    logic                    mail1_n;
    logic                    mail2_n;
    logic                    af_n;
    logic                    ae_n;
    logic                    ef_n;
    logic                    ff_n;
    logic                    porta_parity_err_n_n;
    logic                    portb_parity_err_n_n;
    logic [`FPSC_DW-1:0]     adat;
    logic [`FPSC_DW-1:0]     bdat;
    logic                    aoe;
    logic                    boe;
    logic [5:0]              ops;
  } fpsc_state_t;

endpackage

// File: include/fpsc_par_if.sv
// parity tree hookup between the control block and its parity trees
`timescale 1ns/1ps
`default_nettype none
`include "fpsc_defines.svh"

interface fpsc_par_if;
  logic [`FPSC_DW-1:0]    data;
  logic                   odd;
  logic [`FPSC_DW-1:0]    gen;
  logic [`FPSC_LANES-1:0] ok;
  modport calc (input data, input odd, output gen, output ok);
  modport user (output data, output odd, input gen, input ok);
endinterface

`default_nettype wire

// File: hdl/fpsc_parity.sv
// four 9-bit parity trees: check each byte and regenerate its top bit
`timescale 1ns/1ps
`default_nettype none
`include "fpsc_defines.svh"

module fpsc_parity (
  fpsc_par_if.calc par
);
  genvar g;
  // one tree per byte lane; top bit of a lane is its parity bit
  generate
    for (g = 0; g < `FPSC_LANES; g++) begin : g_lane
      localparam int LO = g * `FPSC_BYTE_W;
      localparam int HI = LO + `FPSC_BYTE_W - 1;
      // odd select high wants an odd count of ones over all nine bits
      assign par.ok[g] = (^par.data[HI:LO]) == par.odd;
      assign par.gen[HI-1:LO] = par.data[HI-1:LO];
      assign par.gen[HI] = (^par.data[HI-1:LO]) ^ par.odd;
    end
  endgenerate
endmodule

`default_nettype wire

// File: hdl/fpsc_ctrl.sv
// pin control of a two-port mailbox fifo: parity, reset, sizing, selects
`timescale 1ns/1ps
`default_nettype none
`include "fpsc_defines.svh"

module fpsc_ctrl
  import fpsc_pkg::*;
(
  input  wire logic                   sys_clk_i,
  input  wire logic                   rst_i,
  input  wire logic                   ce_i,
  input  wire fpsc_pins_t             pins_i,
  input  wire logic [`FPSC_DW-1:0]    mail2_data_i,
  input  wire logic [`FPSC_DW-1:0]    portb_rd_data_i,
  input  wire logic                   core_almost_full_n_i,
  input  wire logic                   core_almost_empty_n_i,
  input  wire logic                   core_empty_n_i,
  input  wire logic                   core_full_n_i,
  output logic [`FPSC_DW-1:0]         porta_data_o,
  output logic                        porta_data_oe_o,
  output logic [`FPSC_DW-1:0]         portb_data_o,
  output logic                        portb_data_oe_o,
  output logic                        porta_parity_err_n_o,
  output logic                        portb_parity_err_n_o,
  output logic [`FPSC_OFS_W-1:0]      offset_o,
  output logic [1:0]                  portb_size_o,
  output logic                        portb_endian_o,
  output fpsc_swap_t                  swap_mode_o,
  output logic                        almost_full_n_o,
  output logic                        almost_empty_n_o,
  output logic                        empty_n_o,
  output logic                        full_n_o,
  output logic                        mail1_flag_n_o,
  output logic                        mail2_flag_n_o,
  output logic                        porta_fifo_wr_o,
  output logic                        porta_mail1_wr_o,
  output logic                        porta_mail2_rd_o,
  output logic                        portb_fifo_rd_o,
  output logic                        portb_mail2_wr_o,
  output logic                        portb_mail1_rd_o
);

  fpsc_state_t            st_r;
  fpsc_state_t            st_nxt;
  fpsc_pins_t             p;
  logic                   a_rise;
  logic                   b_rise;
  logic                   in_rst;
  logic                   rst_rise;
  logic                   b_mbox;
  logic                   gen_a;
  logic                   gen_b;
  logic                   force_a;
  logic                   force_b;
  logic [`FPSC_LANES-1:0] lanes;
  logic                   a_fifo_wr;
  logic                   a_mail1_wr;
  logic                   a_mail2_rd;
  logic                   b_fifo_rd;
  logic                   b_mail2_wr;
  logic                   b_mail1_rd;

  fpsc_par_if par_a ();
  fpsc_par_if par_b ();

  fpsc_parity u_par_a (.par(par_a));
  fpsc_parity u_par_b (.par(par_b));

  // only the second sync stage is looked at; port clocks are sampled pins
  assign p        = st_r.s2;
  assign a_rise   = p.porta_clk & ~st_r.porta_clk_d;
  assign b_rise   = p.portb_clk & ~st_r.portb_clk_d;
  assign in_rst   = ~p.dev_rst_n;
  assign rst_rise = p.dev_rst_n & ~st_r.rst_n_d;
  assign b_mbox   = st_r.size_app[1:0] == `FPSC_SIZE_MBOX;

  // port decodes; reset pin low blocks every operation
  assign a_fifo_wr  = a_rise && !in_rst && !p.porta_chip_sel_n
                      && p.porta_enable && p.porta_write_not_read
                      && !p.porta_mbox_sel && st_r.ff_n;
  assign a_mail1_wr = a_rise && !in_rst && !p.porta_chip_sel_n
                      && p.porta_enable && p.porta_write_not_read
                      && p.porta_mbox_sel && st_r.mail1_n;
  assign a_mail2_rd = a_rise && !in_rst && !p.porta_chip_sel_n
                      && p.porta_enable && !p.porta_write_not_read
                      && p.porta_mbox_sel;
  assign b_mail2_wr = b_rise && !in_rst && !p.portb_chip_sel_n
                      && p.portb_enable && p.portb_write_not_read
                      && b_mbox && st_r.mail2_n;
  assign b_fifo_rd  = b_rise && !in_rst && !p.portb_chip_sel_n
                      && p.portb_enable && !p.portb_write_not_read
                      && !b_mbox && st_r.ef_n;
  assign b_mail1_rd = b_rise && !in_rst && !p.portb_chip_sel_n
                      && p.portb_enable && !p.portb_write_not_read
                      && b_mbox;

  // generation reuses the input trees, so they see outgoing read data
  assign gen_a   = !p.porta_chip_sel_n && !p.porta_write_not_read
                   && p.porta_mbox_sel && p.porta_parity_gen_en;
  assign gen_b   = !p.portb_chip_sel_n && !p.portb_write_not_read
                   && p.portb_parity_gen_en;
  assign force_a = gen_a && p.porta_enable;
  assign force_b = gen_b && p.portb_enable && b_mbox;

  assign par_a.odd  = p.odd_even_sel;
  assign par_b.odd  = p.odd_even_sel;
  assign par_a.data = gen_a ? mail2_data_i : p.porta_data;
  assign par_b.data = gen_b ? portb_rd_data_i : p.portb_data;

  // byte lanes carried by the size now in force
  always_comb begin
    case (st_r.size_app[1:0])
      `FPSC_SIZE_WORD: lanes = `FPSC_LANES_WORD;
      `FPSC_SIZE_BYTE: lanes = `FPSC_LANES_BYTE;
      default:         lanes = `FPSC_LANES_ALL;
    endcase
  end

  // next state; ce_i low keeps everything, synchronisers included
  always_comb begin
    st_nxt = st_r;
    if (ce_i) begin
      st_nxt.s1      = pins_i;
      st_nxt.s2      = st_r.s1;
      st_nxt.porta_clk_d  = p.porta_clk;
      st_nxt.portb_clk_d  = p.portb_clk;
      st_nxt.rst_n_d = p.dev_rst_n;
      st_nxt.ops     = {a_fifo_wr, a_mail1_wr, a_mail2_rd,
                        b_fifo_rd, b_mail2_wr, b_mail1_rd};
      // offset fixed on the reset pin's rising edge only
      if (rst_rise) begin
        case (p.offset_sel)
          `FPSC_OFS_SEL_16: st_nxt.offset = `FPSC_OFS_16;
          `FPSC_OFS_SEL_12: st_nxt.offset = `FPSC_OFS_12;
          `FPSC_OFS_SEL_8:  st_nxt.offset = `FPSC_OFS_8;
          default:          st_nxt.offset = `FPSC_OFS_4;
        endcase
      end
      // size and endian take two port-B edges to come into force
      if (b_rise) begin
        st_nxt.size_lat = {p.portb_endian_sel, p.portb_size_sel};
        st_nxt.size_app = st_r.size_lat;
      end
      // swap picked only on the first unit of a long word, any size
      if (b_fifo_rd) begin
        if (st_r.pos == `FPSC_POS_ZERO) begin
          st_nxt.swap = fpsc_swap_t'(p.swap_sel);
        end
        case (st_r.size_app[1:0])
          `FPSC_SIZE_WORD: st_nxt.pos = st_r.pos + `FPSC_POS_WORD;
          `FPSC_SIZE_BYTE: st_nxt.pos = st_r.pos + `FPSC_POS_BYTE;
          default:         st_nxt.pos = `FPSC_POS_ZERO;
        endcase
      end
      // a new mail1 write wins over a read landing in the same cycle
      if (b_mail1_rd) st_nxt.mail1_n = `FPSC_FLAG_HI;
      if (a_mail1_wr) st_nxt.mail1_n = `FPSC_FLAG_LO;
      if (a_mail2_rd) st_nxt.mail2_n = `FPSC_FLAG_HI;
      if (b_mail2_wr) st_nxt.mail2_n = `FPSC_FLAG_LO;
      st_nxt.af_n = core_almost_full_n_i;
      st_nxt.ae_n = core_almost_empty_n_i;
      st_nxt.ef_n = core_empty_n_i;
      st_nxt.ff_n = core_full_n_i;
      // a failing lane in use drops the flag; generation setup forces it high, on port B in mailbox size only
      st_nxt.porta_parity_err_n_n = force_a || (&par_a.ok);
      st_nxt.portb_parity_err_n_n = force_b || (&(par_b.ok | ~lanes));
      st_nxt.adat   = gen_a ? par_a.gen : mail2_data_i;
      st_nxt.bdat   = gen_b ? par_b.gen : portb_rd_data_i;
      st_nxt.aoe    = !p.porta_chip_sel_n && !p.porta_write_not_read;
      st_nxt.boe    = !p.portb_chip_sel_n && !p.portb_write_not_read;
      // the reset pin overrides flags and long-word position
      if (in_rst) begin
        st_nxt.af_n    = `FPSC_FLAG_HI;
        st_nxt.mail1_n = `FPSC_FLAG_HI;
        st_nxt.mail2_n = `FPSC_FLAG_HI;
        st_nxt.ae_n    = `FPSC_FLAG_LO;
        st_nxt.ef_n    = `FPSC_FLAG_LO;
        st_nxt.ff_n    = `FPSC_FLAG_LO;
        st_nxt.pos     = `FPSC_POS_ZERO;
      end
    end
  end

  // system reset puts the block in the device-reset picture
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      st_r         <= '0;
      st_r.offset  <= `FPSC_OFS_4;
      st_r.af_n    <= `FPSC_FLAG_HI;
      st_r.mail1_n <= `FPSC_FLAG_HI;
      st_r.mail2_n <= `FPSC_FLAG_HI;
      st_r.porta_parity_err_n_n  <= `FPSC_FLAG_HI;
      st_r.portb_parity_err_n_n  <= `FPSC_FLAG_HI;
      st_r.s1.dev_rst_n <= `FPSC_FLAG_HI; // idle pin level: no false rise
      st_r.s2.dev_rst_n <= `FPSC_FLAG_HI;
      st_r.rst_n_d      <= `FPSC_FLAG_HI;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign porta_data_o         = st_r.adat;
  assign porta_data_oe_o      = st_r.aoe;
  assign portb_data_o         = st_r.bdat;
  assign portb_data_oe_o      = st_r.boe;
  assign porta_parity_err_n_o = st_r.porta_parity_err_n_n;
  assign portb_parity_err_n_o = st_r.portb_parity_err_n_n;
  assign offset_o             = st_r.offset;
  assign portb_size_o         = st_r.size_app[1:0];
  assign portb_endian_o       = st_r.size_app[2];
  assign swap_mode_o          = st_r.swap;
  assign almost_full_n_o      = st_r.af_n;
  assign almost_empty_n_o     = st_r.ae_n;
  assign empty_n_o            = st_r.ef_n;
  assign full_n_o             = st_r.ff_n;
  assign mail1_flag_n_o       = st_r.mail1_n;
  assign mail2_flag_n_o       = st_r.mail2_n;
  assign {porta_fifo_wr_o, porta_mail1_wr_o, porta_mail2_rd_o,
          portb_fifo_rd_o, portb_mail2_wr_o, portb_mail1_rd_o} = st_r.ops;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  portb_parity_err_n_lane_err_a: assert property (
    (ce_i && !force_b && |(~par_b.ok & lanes)) |=> !portb_parity_err_n_o)
    else $error("port-B parity error not flagged");
  portb_parity_err_n_unused_lane_a: assert property (
    (ce_i && !force_b && &(par_b.ok | ~lanes)) |=> portb_parity_err_n_o)
    else $error("port-B error raised on unused lane");
  portb_parity_err_n_force_a: assert property (
    (ce_i && force_b) |=> portb_parity_err_n_o)
    else $error("port-B error not forced high in mail1 generation");
  porta_gen_odd_a: assert property (
    (ce_i && gen_a) |=> ((^porta_data_o[8:0]) == $past(p.odd_even_sel)))
    else $error("port-A generated parity wrong");
  portb_gen_odd_a: assert property (
    (ce_i && gen_b) |=> ((^portb_data_o[35:27]) == $past(p.odd_even_sel)))
    else $error("port-B generated parity wrong");
  flags_reset_a: assert property (
    (ce_i && in_rst) |=> (almost_full_n_o && mail1_flag_n_o
      && mail2_flag_n_o && !empty_n_o && !almost_empty_n_o && !full_n_o))
    else $error("flags wrong during device reset");
  offset_load_a: assert property (
    (ce_i && rst_rise && p.offset_sel == `FPSC_OFS_SEL_12)
      |=> offset_o == `FPSC_OFS_12)
    else $error("offset not loaded on reset release");
  size_apply_a: assert property (
    (ce_i && b_rise) |=> (st_r.size_app == $past(st_r.size_lat)))
    else $error("latched size not applied on next edge");
  porta_float_a: assert property (
    (ce_i && p.porta_write_not_read) |=> !porta_data_oe_o)
    else $error("port-A driven while write selected");
  portb_float_a: assert property (
    (ce_i && p.portb_write_not_read) |=> !portb_data_oe_o)
    else $error("port-B driven while write selected");
  mail1_set_a: assert property (
    (ce_i && b_mail1_rd && !a_mail1_wr) |=> mail1_flag_n_o [*1])
    else $error("mail1 flag not set by port-B mailbox read");
  swap_sample_a: assert property (
    (ce_i && b_fifo_rd && st_r.pos == `FPSC_POS_ZERO)
      |=> swap_mode_o == fpsc_swap_t'($past(p.swap_sel)))
    else $error("swap mode not sampled at long-word start");

endmodule

`default_nettype wire

// File: bench/fpsc_port_model.sv
// far-side model: both port controllers plus the reset and strap pins
`timescale 1ns/1ps
`default_nettype none

module fpsc_port_model
  import fpsc_pkg::*;
(
  input  wire logic       sys_clk_i,
  output var  fpsc_pins_t pins_o
);
  // idle: both ports deselected and writing, so the data pins float
  initial begin
    pins_o                      = '0;
    pins_o.dev_rst_n            = 1'b1;
    pins_o.porta_chip_sel_n     = 1'b1;
    pins_o.portb_chip_sel_n     = 1'b1;
    pins_o.porta_write_not_read = 1'b1;
    pins_o.portb_write_not_read = 1'b1;
  end

  // one port clock rise; both phases last over three cycles, though the
  // sampled-clock edge detector would catch phases of a single cycle
  task automatic tick(input logic on_b);
    @(negedge sys_clk_i);
    if (on_b) begin
      pins_o.portb_clk = 1'b1;
    end else begin
      pins_o.porta_clk = 1'b1;
    end
    repeat (4) @(negedge sys_clk_i);
    pins_o.porta_clk = 1'b0;
    pins_o.portb_clk = 1'b0;
    repeat (3) @(negedge sys_clk_i);
  endtask

  // device reset pin low across four rises of each port clock
  task automatic reset_low();
    @(negedge sys_clk_i);
    pins_o.dev_rst_n = 1'b0;
    for (int i = 0; i < 8; i++) begin
      tick(1'(i));
    end
  endtask

  // offset straps settle before the rising edge of the reset pin
  task automatic reset_high(input logic [1:0] ofs);
    pins_o.offset_sel = ofs;
    @(negedge sys_clk_i);
    pins_o.dev_rst_n = 1'b1;
    repeat (5) @(negedge sys_clk_i);
  endtask
endmodule

`default_nettype wire

// File: bench/fpsc_ctrl_tb.sv
// self-checking bench for the fifo port, parity and sizing control block
`timescale 1ns/1ps
`default_nettype none

module fpsc_ctrl_tb import fpsc_pkg::*; ;
  logic        sys_clk_i = 1'b0;
  logic        rst_i     = 1'b1;
  logic        ce        = 1'b1;
  fpsc_pins_t  pins;
  logic [35:0] m2_dat    = '0;
  logic [35:0] rd_dat    = '0;
  logic [3:0]  core_n    = 4'h0;
  logic [35:0] a_dat, b_dat;
  logic [4:0]  offset;
  logic [1:0]  size;
  fpsc_swap_t  swap;
  logic        endian, a_oe, b_oe, porta_parity_err_n_n, portb_parity_err_n_n;
  logic        af_n, ae_n, ef_n, ff_n, m1_n, m2_n;
  wire  [5:0]  ops;
  int          cnt [6];
  int          fail_count = 0;
  int          num_checks = 0;

  fpsc_port_model pm (.sys_clk_i(sys_clk_i), .pins_o(pins));

  fpsc_ctrl dut (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .ce_i(ce), .pins_i(pins),
    .mail2_data_i(m2_dat), .portb_rd_data_i(rd_dat),
    .core_almost_full_n_i(core_n[3]), .core_almost_empty_n_i(core_n[2]),
    .core_empty_n_i(core_n[1]), .core_full_n_i(core_n[0]),
    .porta_data_o(a_dat), .porta_data_oe_o(a_oe), .portb_data_o(b_dat),
    .portb_data_oe_o(b_oe), .porta_parity_err_n_o(porta_parity_err_n_n),
    .portb_parity_err_n_o(portb_parity_err_n_n), .offset_o(offset), .portb_size_o(size),
    .portb_endian_o(endian), .swap_mode_o(swap), .almost_full_n_o(af_n),
    .almost_empty_n_o(ae_n), .empty_n_o(ef_n), .full_n_o(ff_n),
    .mail1_flag_n_o(m1_n), .mail2_flag_n_o(m2_n),
    .porta_fifo_wr_o(ops[5]), .porta_mail1_wr_o(ops[4]),
    .porta_mail2_rd_o(ops[3]), .portb_fifo_rd_o(ops[2]),
    .portb_mail2_wr_o(ops[1]), .portb_mail1_rd_o(ops[0]));

  initial begin
    forever #50 sys_clk_i = ~sys_clk_i;
  end

  // operation pulses are counted so a doubled or missing pulse shows
  always @(posedge sys_clk_i) begin
    for (int i = 0; i < 6; i++) begin
      if (ops[i] === 1'b1) cnt[i]++;
    end
  end

  task automatic conclude();
    if (fail_count == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [35:0] exp,
                     input logic [35:0] got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // per-lane parity good flags; odd parity wants an odd count of ones
  function automatic logic [3:0] lanes_ok(input logic [35:0] d,
                                          input logic odd);
    for (int i = 0; i < 4; i++) lanes_ok[i] = ((^d[i*9+:9]) == odd);
  endfunction

  function automatic logic [35:0] gen_par(input logic [35:0] d,
                                          input logic odd);
    gen_par = d;
    for (int i = 0; i < 4; i++) gen_par[i*9+8] = (^d[i*9+:8]) ^ odd;
  endfunction

  function automatic logic [3:0] lane_mask(input logic [1:0] sz);
    case (sz)
      2'h1:    lane_mask = 4'h1;
      2'h2:    lane_mask = 4'h3;
      default: lane_mask = 4'hF;
    endcase
  endfunction

  task automatic op_tick(input logic on_b, input int k);
    cnt = '{default: 0};
    pm.tick(on_b);
    for (int i = 0; i < 6; i++) begin
      chk("op pulses", 36'(i == k), 36'(cnt[i]));
    end
  endtask

  // port B deselected so the two edges latch the size without an access
  task automatic set_size(input logic [1:0] sz, input logic en);
    logic [1:0] old;
    old = size;
    pm.pins_o.portb_chip_sel_n = 1'b1;
    pm.pins_o.portb_size_sel   = sz;
    pm.pins_o.portb_endian_sel = en;
    pm.tick(1'b1);
    chk("size after latch", 36'(old), 36'(size));
    pm.tick(1'b1);
    chk("size applied", 36'({sz, en}), 36'({size, endian}));
    pm.pins_o.portb_chip_sel_n = 1'b0;
  endtask

  initial begin
    logic [35:0] d;
    logic [1:0]  sz;
    logic        odd, pg, wr;
    void'($urandom(32'hE672CF10));
    repeat (2) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    chk("reset outputs", 36'({offset, size, swap, af_n, ae_n, ef_n, ff_n,
        m1_n, m2_n, porta_parity_err_n_n, portb_parity_err_n_n, a_oe, b_oe}),
        36'({5'h04, 4'h0, 10'h23C}));
    rst_i  = 1'b0;
    core_n = 4'hF;
    // mailbox traffic both ways
    pm.pins_o.porta_chip_sel_n = 1'b0;
    pm.pins_o.porta_enable     = 1'b1;
    pm.pins_o.porta_mbox_sel   = 1'b1;
    op_tick(1'b0, 4);
    chk("mail1 flag set", 36'h0, 36'(m1_n));
    set_size(2'h3, 1'b0);
    pm.pins_o.portb_enable         = 1'b1;
    pm.pins_o.portb_write_not_read = 1'b0;
    op_tick(1'b1, 0);
    chk("mail1 flag clear", 36'h1, 36'(m1_n));
    pm.pins_o.portb_write_not_read = 1'b1;
    op_tick(1'b1, 1);
    chk("mail2 flag set", 36'h0, 36'(m2_n));
    pm.pins_o.porta_write_not_read = 1'b0;
    op_tick(1'b0, 3);
    chk("mail2 flag clear", 36'h1, 36'(m2_n));
    // every swap code on long-word reads, then mid-word in byte size
    pm.pins_o.portb_write_not_read = 1'b0;
    set_size(2'h0, 1'b0);
    for (int s = 0; s < 4; s++) begin
      pm.pins_o.swap_sel = 2'(s);
      op_tick(1'b1, 2);
      chk("swap mode", 36'(s), 36'(swap));
    end
    set_size(2'h1, 1'b1);
    pm.pins_o.swap_sel = 2'h2;
    op_tick(1'b1, 2);
    pm.pins_o.swap_sel = 2'h1;
    op_tick(1'b1, 2);
    chk("swap mid word", 36'h2, 36'(swap));
    // random parity traffic, one bad bit in about half the words
    for (int n = 0; n < 24; n++) begin
      sz = (n == 0) ? 2'h3 : 2'($urandom);
      set_size(sz, 1'($urandom));
      odd = 1'($urandom);
      pg  = (n < 2) | 1'($urandom);
      wr  = (n >= 2) & 1'($urandom);
      d   = gen_par(36'({$urandom, $urandom}), odd);
      if ($urandom % 2) d[$urandom % 36] ^= 1'b1;
      pm.pins_o.portb_data           = d;
      pm.pins_o.porta_data           = {d[26:0], d[35:27]};
      pm.pins_o.odd_even_sel         = odd;
      pm.pins_o.portb_parity_gen_en  = pg;
      pm.pins_o.porta_parity_gen_en  = pg;
      pm.pins_o.portb_write_not_read = wr;
      pm.pins_o.porta_write_not_read = ~wr;
      rd_dat = 36'({$urandom, $urandom});
      m2_dat = 36'({$urandom, $urandom});
      repeat (5) @(negedge sys_clk_i);
      // port-B generation borrows the trees, which then see the read data
      chk("portb parity", 36'((sz == 2'h3 && pg && !wr) ||
          &(lanes_ok((pg && !wr) ? rd_dat : d, odd) | ~lane_mask(sz))),
          36'(portb_parity_err_n_n));
      chk("porta parity", 36'((pg && wr) ||
          &lanes_ok(pins.porta_data, odd)), 36'(porta_parity_err_n_n));
      chk("portb drive", 36'(!wr), 36'(b_oe));
      chk("porta drive", 36'(wr), 36'(a_oe));
      if (!wr) chk("portb data", pg ? gen_par(rd_dat, odd) : rd_dat, b_dat);
      else chk("porta data", pg ? gen_par(m2_dat, odd) : m2_dat, a_dat);
    end
    // core flags and port-A writes, then device reset pin: forced flags and every offset strap code
    core_n = 4'h7;
    pm.pins_o.porta_write_not_read = 1'b1;
    op_tick(1'b0, 4);
    pm.pins_o.porta_mbox_sel = 1'b0;
    op_tick(1'b0, 5);
    chk("core flags", 36'h7, 36'({af_n, ae_n, ef_n, ff_n}));
    // full flag low refuses the fifo write: no pulse at all
    core_n = 4'h6;
    op_tick(1'b0, 6);
    for (int k = 3; k >= 0; k--) begin
      pm.reset_low();
      chk("flags in reset", 36'h23,
          36'({af_n, ae_n, ef_n, ff_n, m1_n, m2_n}));
      pm.reset_high(2'(k));
      chk("offset", 36'(4 * (k + 1)), 36'(offset));
    end
    // clock enable low: a device reset on the pins must change nothing
    ce = 1'b0;
    pm.pins_o.dev_rst_n = 1'b0;
    repeat (5) @(negedge sys_clk_i);
    chk("frozen flags", 36'h1B,
        36'({af_n, ae_n, ef_n, ff_n, m1_n, m2_n}));
    pm.pins_o.dev_rst_n = 1'b1;
    ce = 1'b1;
    repeat (3) @(negedge sys_clk_i);
    conclude();
  end

  // the whole run needs well under 5000 cycles
  initial begin
    repeat (30000) @(posedge sys_clk_i);
    fail_count++;
    conclude();
  end
endmodule

`default_nettype wire
